// >>> hw/cfg_word_pkg.sv
// Constants for the configuration word decoder: offsets, fields, reset values.
// Assumes a 32-bit APB bus; registers sit one per aligned word.
package cfg_word_pkg;
  // Printed offsets are word indices, not byte addresses: byte address = 4*index
  localparam logic [15:0] USER_ID_IDX0  = 16'h8000;
  localparam logic [15:0] REV_ID_IDX    = 16'h8005;
  localparam logic [15:0] DEV_ID_IDX    = 16'h8006;
  localparam logic [15:0] CFG1_IDX      = 16'h8007;
  localparam logic [15:0] CFG2_IDX      = 16'h8008;
  localparam logic [15:0] CFG_LAST_IDX  = 16'h800B;
  localparam logic [15:0] PROT_IDX      = 16'h8009;
  localparam logic [15:0] APPLY_IDX     = 16'h800C;
  localparam logic [15:0] STATUS_IDX    = 16'h800D;
  localparam int          ADDR_W        = 18;

  // Implemented-bit masks (others read zero)
  localparam logic [15:0] CFG1_MASK     = 16'h1133;
  localparam logic [15:0] CFG2_MASK     = 16'h3ADF;
  localparam logic [15:0] PROT_MASK     = 16'h008F;
  localparam logic [15:0] ID_MASK       = 16'h3FFF;
  localparam logic [15:0] CFG1_RESET    = 16'h1111;
  localparam logic [15:0] CFG2_RESET    = 16'h3ADF;
  localparam logic [15:0] PROT_RESET    = 16'h008F;

  // Field positions
  localparam int ANALOG_BIT   = 12;
  localparam int CLOCK_OUTPUT_PIN_BIT   = 8;
  localparam int PWRUP_OSC_LO = 4;
  localparam int EXT_MODE_LO  = 0;
  localparam int DEBUG_BIT    = 13;
  localparam int STACK_BIT    = 12;
  localparam int BROWN_LO     = 6;
  localparam int WDOG_LO      = 3;
  localparam int PDLY_LO      = 1;
  localparam int CP_BIT       = 7;

  localparam int CLK_DIV      = 4;
  localparam logic [1:0] CLK_DIV_LAST = 2'h1;

  typedef enum logic [3:0] {
    OSC_EXT     = 4'h1,
    OSC_FAST1   = 4'h2,
    OSC_SLOW    = 4'h4,
    OSC_FAST32  = 4'h8
  } osc_sel_t;

  typedef enum logic [3:0] {
    EXT_HIGH    = 4'h1,
    EXT_LOW     = 4'h2,
    EXT_OFF     = 4'h4,
    EXT_RSVD    = 4'h8
  } ext_mode_t;

  typedef enum logic [3:0] {
    MODE_ALWAYS = 4'h1,
    MODE_AWAKE  = 4'h2,
    MODE_SOFT   = 4'h4,
    MODE_OFF    = 4'h8
  } enable_mode_t;

  typedef enum logic [3:0] {
    PDLY_OFF    = 4'h1,
    PDLY_64MS   = 4'h2,
    PDLY_16MS   = 4'h4,
    PDLY_1MS    = 4'h8
  } pdly_t;

  function automatic enable_mode_t decode_enable(input logic [1:0] code);
    case (code)
      2'h3:    decode_enable = MODE_ALWAYS;
      2'h2:    decode_enable = MODE_AWAKE;
      2'h1:    decode_enable = MODE_SOFT;
      default: decode_enable = MODE_OFF;
    endcase
  endfunction
endpackage

// >>> hw/device_config_word_decoder.sv
// Configuration word store, decode and protection for the device core.
// Assumes an APB master on clk; settings apply at reset or on an apply strobe.
`timescale 1ns/100ps
module device_config_word_decoder
  import cfg_word_pkg::*;
#(
  parameter logic [13:0] DEVICE_ID   = 14'h0123, // Arbitrary value
  parameter logic [13:0] REVISION_ID = 14'h0042  // Arbitrary value
)
(
  input  wire logic              clk,
  input  wire logic              rst_b,
  input  wire logic              psel,
  input  wire logic              penable,
  input  wire logic              pwrite,
  input  wire logic [ADDR_W-1:0] paddr,
  input  wire logic [31:0]       pwdata,
  output logic      [31:0]       prdata,
  output logic                   pready,
  output logic                   pslverr,
  input  wire logic              stack_overflow_flag,
  input  wire logic              stack_underflow_flag,
  input  wire logic              ext_req,
  input  wire logic              ext_wr,
  input  wire logic              self_wr,
  input  wire logic [13:0]       pm_addr,
  input  wire logic [13:0]       pm_rdata,
  output logic      [13:0]       ext_rdata,
  output logic                   ext_wr_ok,
  output logic                   self_wr_ok,
  output logic                   clock_output_pin,
  output logic                   clock_output_oe,
  output logic                   analog_range_select,
  output logic                   debugger_enable,
  output logic                   stack_reset_req,
  output osc_sel_t               current_oscillator_select,
  output ext_mode_t              external_oscillator_mode,
  output enable_mode_t           watchdog_mode,
  output enable_mode_t           brownout_mode,
  output pdly_t                  powerup_delay_mode
);
  logic [15:0] cfg1_nv_r;
  logic [15:0] cfg2_nv_r;
  logic [15:0] prot_nv_r;
  logic [15:0] cfg1_act_r;
  logic [15:0] cfg2_act_r;
  logic [15:0] prot_act_r;
  logic [13:0] user_id_r [4];
  logic        apply_r;
  logic [1:0]  div_r;
  logic        ovf_s1_r;
  logic        ovf_s2_r;
  logic        unf_s1_r;
  logic        unf_s2_r;
  logic [15:0] idx;
  logic        wr_en;
  logic        rd_en;
  logic [31:0] rd_nxt;
  logic        hit;

  pm_guard_if g ();

  assign idx   = paddr[ADDR_W-1:2];
  assign wr_en = psel & penable & pwrite;
  assign rd_en = psel & penable & ~pwrite;

  // Address decode and read mux
  always_comb
  begin
    hit    = 1'b1;
    rd_nxt = 32'h0000_0000;
    case (idx)
      CFG1_IDX:   rd_nxt = {16'h0000, cfg1_nv_r & CFG1_MASK};
      CFG2_IDX:   rd_nxt = {16'h0000, cfg2_nv_r & CFG2_MASK};
      PROT_IDX:   rd_nxt = {16'h0000, prot_nv_r & PROT_MASK};
      16'h800A,
      CFG_LAST_IDX: rd_nxt = 32'h0000_0000;
      REV_ID_IDX: rd_nxt = {18'h00000, REVISION_ID};
      DEV_ID_IDX: rd_nxt = {18'h00000, DEVICE_ID};
      STATUS_IDX: rd_nxt = {31'h0000_0000, stack_reset_req};
      APPLY_IDX:  rd_nxt = 32'h0000_0000;
      default:
      begin
        if (idx[15:2] == USER_ID_IDX0[15:2])
          rd_nxt = {18'h00000, user_id_r[idx[1:0]]};
        else
          hit = 1'b0;
      end
    endcase
  end

  // Zero-wait-state APB answer
  always_ff @(posedge clk)
  begin
    if (!rst_b)
    begin
      pready  <= 1'b0;
      pslverr <= 1'b0;
      prdata  <= 32'h0000_0000;
    end
    else
    begin
      pready  <= psel & ~penable;
      pslverr <= psel & ~penable & ~hit;
      prdata  <= (psel & ~penable & ~pwrite) ? rd_nxt : 32'h0000_0000;
    end
  end

  // Nonvolatile images: writes here take effect only at the next apply; reset reloads the reset values
  always_ff @(posedge clk)
  begin
    if (!rst_b)
    begin
      cfg1_nv_r <= CFG1_RESET;
      cfg2_nv_r <= CFG2_RESET;
      prot_nv_r <= PROT_RESET;
    end
    else if (wr_en && pready)
    begin
      case (idx)
        CFG1_IDX: cfg1_nv_r <= pwdata[15:0] & CFG1_MASK;
        CFG2_IDX: cfg2_nv_r <= pwdata[15:0] & CFG2_MASK;
        PROT_IDX: prot_nv_r <= pwdata[15:0] & PROT_MASK;
        default:  cfg1_nv_r <= cfg1_nv_r;
      endcase
    end
  end

  always_ff @(posedge clk)
  begin
    if (!rst_b)
    begin
      for (int i = 0; i < 4; i++)
        user_id_r[i] <= 14'h0000;
    end
    else if (wr_en && pready && idx[15:2] == USER_ID_IDX0[15:2])
      user_id_r[idx[1:0]] <= pwdata[13:0];
  end

  always_ff @(posedge clk)
  begin
    if (!rst_b)
      apply_r <= 1'b1;
    else
      apply_r <= wr_en & pready & (idx == APPLY_IDX) & pwdata[0];
  end

  // Active copies change only when reset releases or software asks
  always_ff @(posedge clk)
  begin
    if (!rst_b)
    begin
      cfg1_act_r <= CFG1_RESET;
      cfg2_act_r <= CFG2_RESET;
      prot_act_r <= PROT_RESET;
    end
    else if (apply_r)
    begin
      cfg1_act_r <= cfg1_nv_r;
      cfg2_act_r <= cfg2_nv_r;
      prot_act_r <= prot_nv_r;
    end
  end

  // Decoded outputs registered
  always_ff @(posedge clk)
  begin
    if (!rst_b)
    begin
      analog_range_select       <= 1'b1;
      debugger_enable           <= 1'b0;
      current_oscillator_select <= OSC_SLOW;
      external_oscillator_mode  <= EXT_OFF;
      watchdog_mode             <= MODE_ALWAYS;
      brownout_mode             <= MODE_ALWAYS;
      powerup_delay_mode        <= PDLY_OFF;
    end
    else
    begin
      analog_range_select <= cfg1_act_r[ANALOG_BIT];
      debugger_enable     <= ~cfg2_act_r[DEBUG_BIT];
      case (cfg1_act_r[PWRUP_OSC_LO +: 2])
        2'h3:    current_oscillator_select <= OSC_EXT;
        2'h2:    current_oscillator_select <= OSC_FAST1;
        2'h1:    current_oscillator_select <= OSC_SLOW;
        default: current_oscillator_select <= OSC_FAST32;
      endcase
      case (cfg1_act_r[EXT_MODE_LO +: 2])
        2'h3:    external_oscillator_mode <= EXT_HIGH;
        2'h2:    external_oscillator_mode <= EXT_LOW;
        2'h1:    external_oscillator_mode <= EXT_OFF;
        default: external_oscillator_mode <= EXT_RSVD;
      endcase
      watchdog_mode <= decode_enable(cfg2_act_r[WDOG_LO +: 2]);
      brownout_mode <= decode_enable(cfg2_act_r[BROWN_LO +: 2]);
      case (cfg2_act_r[PDLY_LO +: 2])
        2'h3:    powerup_delay_mode <= PDLY_OFF;
        2'h2:    powerup_delay_mode <= PDLY_64MS;
        2'h1:    powerup_delay_mode <= PDLY_16MS;
        default: powerup_delay_mode <= PDLY_1MS;
      endcase
    end
  end

  // Stack fault flags arrive from the core pins; synchronise first
  always_ff @(posedge clk)
  begin
    if (!rst_b)
    begin
      ovf_s1_r <= 1'b0;
      ovf_s2_r <= 1'b0;
      unf_s1_r <= 1'b0;
      unf_s2_r <= 1'b0;
      stack_reset_req <= 1'b0;
    end
    else
    begin
      ovf_s1_r <= stack_overflow_flag;
      ovf_s2_r <= ovf_s1_r;
      unf_s1_r <= stack_underflow_flag;
      unf_s2_r <= unf_s1_r;
      stack_reset_req <= cfg2_act_r[STACK_BIT] & (ovf_s2_r | unf_s2_r);
    end
  end

  // Oscillator over four; clk stands in for the oscillator here
  always_ff @(posedge clk)
  begin
    if (!rst_b)
    begin
      div_r            <= 2'h0;
      clock_output_pin <= 1'b0;
      clock_output_oe  <= 1'b0;
    end
    else
    begin
      div_r <= div_r + 2'h1;
      if (div_r[0])
        clock_output_pin <= ~clock_output_pin;
      clock_output_oe <= ~cfg1_act_r[CLOCK_OUTPUT_PIN_BIT];
    end
  end

  assign g.ext_req                 = ext_req;
  assign g.ext_wr                  = ext_wr;
  assign g.self_wr                 = self_wr;
  assign g.addr                    = pm_addr;
  assign g.code_protect_n          = prot_act_r[CP_BIT];
  assign g.self_write_protect_bits = prot_act_r[3:0];
  // Boot block end fixed; a size field would have to drive this instead
  assign g.boot_end                = 14'h01FF;

  pm_access_guard u_guard (
    .g (g)
  );

  // Results one cycle after the request, as the tool side expects
  always_ff @(posedge clk)
  begin
    if (!rst_b)
    begin
      ext_rdata  <= 14'h0000;
      ext_wr_ok  <= 1'b0;
      self_wr_ok <= 1'b0;
    end
    else
    begin
      ext_rdata  <= (g.ext_allow && !ext_wr) ? pm_rdata : 14'h0000;
      ext_wr_ok  <= g.ext_allow & ext_wr;
      self_wr_ok <= g.self_wr_allow;
    end
  end

  a_apb_answer: assert property (@(posedge clk) disable iff (!rst_b)
    psel && !penable |=> pready)
    else $error("pready missing after setup");
  a_cp_zero_read: assert property (@(posedge clk) disable iff (!rst_b)
    !prot_act_r[CP_BIT] |=> ext_rdata == 14'h0000 && !ext_wr_ok)
    else $error("protected external access leaked");
  a_id_ro: assert property (@(posedge clk) disable iff (!rst_b)
    wr_en && pready && (idx == DEV_ID_IDX || idx == REV_ID_IDX) |=>
    $stable(cfg1_nv_r) && $stable(cfg2_nv_r) && $stable(prot_nv_r))
    else $error("id write disturbed state");
  a_analog_follow: assert property (@(posedge clk) disable iff (!rst_b)
    1'b1 |=> analog_range_select == $past(cfg1_act_r[ANALOG_BIT]))
    else $error("analog range wrong");
  a_clock_output_pin_oe: assert property (@(posedge clk) disable iff (!rst_b)
    1'b1 |=> clock_output_oe == !$past(cfg1_act_r[CLOCK_OUTPUT_PIN_BIT]))
    else $error("clock out enable wrong");
  a_debug_inv: assert property (@(posedge clk) disable iff (!rst_b)
    1'b1 |=> debugger_enable != $past(cfg2_act_r[DEBUG_BIT]))
    else $error("debug enable wrong");
  a_stack_reset: assert property (@(posedge clk) disable iff (!rst_b)
    stack_reset_req |-> cfg2_act_r[STACK_BIT] || $past(cfg2_act_r[STACK_BIT]))
    else $error("stack reset while disabled");
  a_cfg_hold: assert property (@(posedge clk) disable iff (!rst_b)
    !apply_r |=> $stable(cfg1_act_r) && $stable(cfg2_act_r))
    else $error("active config changed without apply");
  a_unimpl_zero: assert property (@(posedge clk) disable iff (!rst_b)
    (cfg1_nv_r & ~CFG1_MASK) == 16'h0000)
    else $error("unimplemented bit set");

  // Bus answer, identity, protection, apply and stack reset checks
  a_ready_pulse: assert property (@(posedge clk) disable iff (!rst_b)
    pready |=> !pready)
    else $error("pready held too long");
  a_rd_unimpl1: assert property (@(posedge clk) disable iff (!rst_b)
    rd_en && pready && idx == CFG1_IDX |-> prdata == {16'h0000, prdata[15:0] & CFG1_MASK})
    else $error("cfg1 unimplemented bit read nonzero");
  a_rd_unimpl2: assert property (@(posedge clk) disable iff (!rst_b)
    rd_en && pready && idx == CFG2_IDX |-> prdata == {16'h0000, prdata[15:0] & CFG2_MASK})
    else $error("cfg2 unimplemented bit read nonzero");
  a_dev_id_rd: assert property (@(posedge clk) disable iff (!rst_b)
    rd_en && pready && idx == DEV_ID_IDX |-> prdata == {18'h00000, DEVICE_ID})
    else $error("device id read wrong");
  a_rev_id_rd: assert property (@(posedge clk) disable iff (!rst_b)
    rd_en && pready && idx == REV_ID_IDX |-> prdata == {18'h00000, REVISION_ID})
    else $error("revision id read wrong");
  a_ext_pass: assert property (@(posedge clk) disable iff (!rst_b)
    ext_req && !ext_wr && prot_act_r[CP_BIT] |=> ext_rdata == $past(pm_rdata))
    else $error("unprotected external read lost");
  a_self_wr_gate: assert property (@(posedge clk) disable iff (!rst_b)
    self_wr && ((pm_addr <= g.boot_end) ? !prot_act_r[0] : !prot_act_r[1]) |=> !self_wr_ok)
    else $error("protected block accepted self-write");
  a_self_wr_pass: assert property (@(posedge clk) disable iff (!rst_b)
    self_wr && ((pm_addr <= g.boot_end) ? prot_act_r[0] : prot_act_r[1]) |=> self_wr_ok)
    else $error("unprotected self-write refused");
  a_apply_copy: assert property (@(posedge clk) disable iff (!rst_b)
    apply_r |=> cfg1_act_r == $past(cfg1_nv_r) && cfg2_act_r == $past(cfg2_nv_r) &&
    prot_act_r == $past(prot_nv_r))
    else $error("apply did not copy images");
  a_user_id_wr: assert property (@(posedge clk) disable iff (!rst_b)
    wr_en && pready && idx[15:2] == USER_ID_IDX0[15:2] |=>
    user_id_r[$past(idx[1:0])] == $past(pwdata[13:0]))
    else $error("user id write lost");
  a_stack_fire: assert property (@(posedge clk) disable iff (!rst_b)
    cfg2_act_r[STACK_BIT] && (ovf_s2_r || unf_s2_r) |=> stack_reset_req)
    else $error("stack fault reset missing");
endmodule

// >>> hw/pm_access_guard.sv
// Combinational program-memory access guard.
// Assumes latched protection settings from the decoder.
`timescale 1ns/100ps
module pm_access_guard
  import cfg_word_pkg::*;
(
  pm_guard_if.checker_side g
);
  logic in_boot;

  always_comb
  begin
    in_boot = (g.addr <= g.boot_end);
    // Outside tools see nothing while protected
    g.ext_allow = g.ext_req & g.code_protect_n;
    // Bit 0 boot, bit 1 application; refused when the bit is zero
    if (in_boot)
      g.self_wr_allow = g.self_wr & g.self_write_protect_bits[0];
    else
      g.self_wr_allow = g.self_wr & g.self_write_protect_bits[1];
  end
endmodule

// >>> hw/pm_guard_if.sv
// Carries program-memory access requests to the protection checker.
// Assumes a single clock domain.
`timescale 1ns/100ps
interface pm_guard_if;
  logic        ext_req;
  logic        ext_wr;
  logic        self_wr;
  logic [13:0] addr;
  logic        code_protect_n;
  logic [3:0]  self_write_protect_bits;
  logic [13:0] boot_end;
  logic        ext_allow;
  logic        self_wr_allow;
  modport master (output ext_req, ext_wr, self_wr, addr, code_protect_n,
                  self_write_protect_bits, boot_end, input ext_allow, self_wr_allow);
  modport checker_side (input ext_req, ext_wr, self_wr, addr, code_protect_n,
                        self_write_protect_bits, boot_end, output ext_allow, self_wr_allow);
endinterface

// >>> testbench/device_config_word_decoder_tb.sv
// Self-checking bench: APB master, reference model, programmer model.
// Assumes the design package and the programmer model are compiled first.
`timescale 1ns/100ps
module device_config_word_decoder_tb
  import cfg_word_pkg::*;
;
  localparam logic [13:0] DEV_VAL = 14'h2D4B; // Arbitrary value
  localparam logic [13:0] REV_VAL = 14'h0A17; // Arbitrary value
  logic              clk, rst_b, psel, penable, pwrite;
  logic [ADDR_W-1:0] paddr;
  logic [31:0]       pwdata, prdata;
  logic              pready, pslverr, stack_overflow_flag, stack_underflow_flag;
  logic              ext_req, ext_wr, self_wr, ext_wr_ok, self_wr_ok;
  logic [13:0]       pm_addr, pm_rdata, ext_rdata;
  logic              clock_output_pin, clock_output_oe, analog_range_select;
  logic              debugger_enable, stack_reset_req;
  osc_sel_t          current_oscillator_select;
  ext_mode_t         external_oscillator_mode;
  enable_mode_t      watchdog_mode, brownout_mode;
  pdly_t             powerup_delay_mode;
  int                miscompares = 0;
  int                checks = 0;
  integer            seed = 32'hCA41;
  logic [15:0]       act1, act2;
  int                uidq[$];

  device_config_word_decoder #(.DEVICE_ID(DEV_VAL), .REVISION_ID(REV_VAL)) u_device_config_word_decoder
  (
    .clk, .rst_b, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr,
    .stack_overflow_flag, .stack_underflow_flag, .ext_req, .ext_wr, .self_wr, .pm_addr,
    .pm_rdata, .ext_rdata, .ext_wr_ok, .self_wr_ok, .clock_output_pin, .clock_output_oe,
    .analog_range_select, .debugger_enable, .stack_reset_req, .current_oscillator_select,
    .external_oscillator_mode, .watchdog_mode, .brownout_mode, .powerup_delay_mode
  );

  prog_tool_model u_prog_tool_model
  (
    .clk, .ext_rdata, .ext_wr_ok, .self_wr_ok, .ext_req, .ext_wr, .self_wr, .pm_addr, .pm_rdata
  );

  always #5 clk = ~clk;

  task automatic close_out();
    if (miscompares == 0 && checks > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask

  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    checks++;
    if (got !== exp)
    begin
      miscompares++;
      $display("ERROR %s expected %h seen %h", what, exp, got);
    end
  endtask

  task automatic apb(input logic w, input logic [15:0] idx, input logic [31:0] d,
                     output logic [31:0] q, output logic e);
    int n;
    @(posedge clk);
    psel <= 1'h1;
    penable <= 1'h0;
    pwrite <= w;
    paddr <= {idx, 2'h0};
    pwdata <= d;
    @(posedge clk);
    penable <= 1'h1;
    n = 0;
    do
    begin
      @(posedge clk);
      n++;
    end
    while (pready !== 1'h1 && n < 20);
    q = prdata;
    e = pslverr;
    psel <= 1'h0;
    penable <= 1'h0;
    chk("pready", 32'h1, {31'h0, pready});
  endtask

  task automatic wr(input logic [15:0] idx, input logic [31:0] d);
    logic [31:0] q;
    logic        e;
    apb(1'h1, idx, d, q, e);
  endtask

  task automatic rdc(input string what, input logic [15:0] idx, input logic [31:0] exp);
    logic [31:0] q;
    logic        e;
    apb(1'h0, idx, 32'h0, q, e);
    chk(what, exp, q);
  endtask

  // All two-bit decoded fields map code 3..0 onto one-hot 1,2,4,8
  function automatic logic [3:0] oh(input logic [1:0] c);
    oh = 4'h1 << (2'h3 - c);
  endfunction

  // Apply lands, active copy follows, decoded outputs one edge later
  task automatic chk_dec();
    repeat (2) @(posedge clk);
    #1;
    chk("analog", {31'h0, act1[12]}, {31'h0, analog_range_select});
    chk("clk_oe", {31'h0, ~act1[8]}, {31'h0, clock_output_oe});
    chk("debug", {31'h0, ~act2[13]}, {31'h0, debugger_enable});
    chk("osc", {28'h0, oh(act1[5:4])}, {28'h0, current_oscillator_select});
    chk("ext", {28'h0, oh(act1[1:0])}, {28'h0, external_oscillator_mode});
    chk("wdog", {28'h0, oh(act2[4:3])}, {28'h0, watchdog_mode});
    chk("brown", {28'h0, oh(act2[7:6])}, {28'h0, brownout_mode});
    chk("pdly", {28'h0, oh(act2[2:1])}, {28'h0, powerup_delay_mode});
  endtask

  initial
  begin
    #200000;
    miscompares++;
    close_out();
  end

  initial
  begin
    logic [31:0] q, v;
    logic [15:0] pt [3];
    logic [15:0] img1;
    logic [13:0] rd;
    logic [4:0]  s;
    logic        e, ok;
    int          n;
    clk = 1'h0;
    rst_b = 1'h0;
    psel = 1'h0;
    penable = 1'h0;
    pwrite = 1'h0;
    paddr = '0;
    pwdata = 32'h0;
    stack_overflow_flag = 1'h0;
    stack_underflow_flag = 1'h0;
    act1 = CFG1_RESET;
    act2 = CFG2_RESET;
    pt = '{16'h008F, 16'h0001, 16'h0082};
    repeat (4) @(posedge clk);
    rst_b <= 1'h1;
    chk_dec();
    rdc("cfg1", CFG1_IDX, {16'h0, CFG1_RESET});
    rdc("cfg2", CFG2_IDX, {16'h0, CFG2_RESET});
    rdc("dev_id", DEV_ID_IDX, {18'h0, DEV_VAL});
    rdc("rev_id", REV_ID_IDX, {18'h0, REV_VAL});
    wr(DEV_ID_IDX, ~{18'h0, DEV_VAL});
    wr(REV_ID_IDX, 32'hFFFFFFFF);
    rdc("dev_id_ro", DEV_ID_IDX, {18'h0, DEV_VAL});
    rdc("rev_id_ro", REV_ID_IDX, {18'h0, REV_VAL});
    wr(CFG_LAST_IDX, 32'hFFFFFFFF);
    rdc("cfg_last", CFG_LAST_IDX, 32'h0);
    apb(1'h0, 16'h8004, 32'h0, q, e);
    chk("unmapped_err", 32'h1, {31'h0, e});
    for (int i = 0; i < 4; i++)
    begin
      v = $random(seed) & 32'h3FFF;
      uidq.push_back(v);
      wr(USER_ID_IDX0 + 16'(i), v);
    end
    for (int i = 0; i < 4; i++)
      rdc("user_id", USER_ID_IDX0 + 16'(i), uidq.pop_front());
    for (int c = 0; c < 4; c++)
    begin
      v = $random(seed);
      v[12] = c[0];
      v[8] = c[1];
      v[5:4] = c[1:0];
      v[1:0] = c[1:0];
      wr(CFG1_IDX, v);
      rdc("cfg1_img", CFG1_IDX, v & {16'h0, CFG1_MASK});
      img1 = v[15:0] & CFG1_MASK;
      v = $random(seed);
      v[13] = c[0];
      v[12] = c[1];
      v[7:6] = c[1:0];
      v[4:3] = c[1:0];
      v[2:1] = c[1:0];
      wr(CFG2_IDX, v);
      rdc("cfg2_img", CFG2_IDX, v & {16'h0, CFG2_MASK});
      chk_dec();
      wr(APPLY_IDX, 32'h1);
      act1 = img1;
      act2 = v[15:0] & CFG2_MASK;
      chk_dec();
      if (act1[8] == 1'h0)
      begin
        for (int k = 0; k < 5; k++)
        begin
          @(posedge clk);
          #1;
          s[k] = clock_output_pin;
        end
        chk("clock_output_pin_half", {31'h0, ~s[0]}, {31'h0, s[2]});
        chk("clock_output_pin_period", {31'h0, s[0]}, {31'h0, s[4]});
      end
    end
    foreach (pt[k])
    begin
      wr(PROT_IDX, {16'hFF70, pt[k]});
      wr(APPLY_IDX, 32'h1);
      rdc("prot", PROT_IDX, {16'h0, pt[k] & PROT_MASK});
      u_prog_tool_model.access(1'h1, 1'h0, 14'h0123, rd, ok);
      chk("ext_rd", pt[k][7] ? {18'h0, 14'h0123 ^ 14'h155A} : 32'h0, {18'h0, rd});
      u_prog_tool_model.access(1'h1, 1'h1, 14'h0123, rd, ok);
      chk("ext_wr", {31'h0, pt[k][7]}, {31'h0, ok});
      u_prog_tool_model.access(1'h0, 1'h1, 14'h01FF, rd, ok);
      chk("self_boot", {31'h0, pt[k][0]}, {31'h0, ok});
      u_prog_tool_model.access(1'h0, 1'h1, 14'h0200, rd, ok);
      chk("self_app", {31'h0, pt[k][1]}, {31'h0, ok});
    end
    wr(CFG2_IDX, {16'h0, act2 & 16'hEFFF});
    wr(APPLY_IDX, 32'h1);
    repeat (2) @(posedge clk);
    stack_overflow_flag <= 1'h1;
    repeat (6) @(posedge clk);
    #1;
    chk("stack_off", 32'h0, {31'h0, stack_reset_req});
    @(posedge clk);
    stack_overflow_flag <= 1'h0;
    repeat (4) @(posedge clk);
    wr(CFG2_IDX, {16'h0, act2 | 16'h1000});
    wr(APPLY_IDX, 32'h1);
    stack_underflow_flag <= 1'h1;
    n = 0;
    while (stack_reset_req !== 1'h1 && n < 10)
    begin
      @(posedge clk);
      n++;
    end
    chk("stack_on", 32'h1, {31'h0, stack_reset_req});
    rdc("status", STATUS_IDX, 32'h1);
    close_out();
  end
endmodule

// >>> testbench/prog_tool_model.sv
// External programmer model on the program-memory port; also plays the memory.
// Assumes the bench calls access() from one thread, on clk.
`timescale 1ns/100ps
module prog_tool_model
(
  input  wire logic        clk,
  input  wire logic [13:0] ext_rdata,
  input  wire logic        ext_wr_ok,
  input  wire logic        self_wr_ok,
  output logic             ext_req,
  output logic             ext_wr,
  output logic             self_wr,
  output logic [13:0]      pm_addr,
  output logic [13:0]      pm_rdata
);
  initial
  begin
    ext_req = 1'h0;
    ext_wr = 1'h0;
    self_wr = 1'h0;
    pm_addr = 14'h0000;
    pm_rdata = 14'h3FFF;
  end

  // CPU self-writes share the address lines, so they are issued here too
  task automatic access(input logic ext, input logic wr, input logic [13:0] a,
                        output logic [13:0] rd, output logic ok);
    @(posedge clk);
    ext_req <= ext;
    ext_wr <= ext & wr;
    self_wr <= ~ext & wr;
    pm_addr <= a;
    pm_rdata <= a ^ 14'h155A;
    repeat (2) @(posedge clk);
    #1;
    rd = ext_rdata;
    ok = ext ? ext_wr_ok : self_wr_ok;
    @(posedge clk);
    ext_req <= 1'h0;
    ext_wr <= 1'h0;
    self_wr <= 1'h0;
    // Released lines show no stale value
    pm_addr <= ~a;
    pm_rdata <= ~(a ^ 14'h155A);
  endtask
endmodule
